// ===== verilog/fcsu_host.sv
// Host controller that runs command sequences on a parallel NOR flash.
// Assumes pins are synchronous to CORE_CLK and the bench resolves DQ.
`default_nettype none

module fcsu_host (
	// Clock and reset
	input wire logic CORE_CLK,
	input wire logic RESET_N,
	// User order port
	input wire logic REQ_VALID,
	input wire fcsu_pkg::fcsu_req_t REQ,
	output logic REQ_READY,
	output logic RSP_VALID,
	output fcsu_pkg::fcsu_rsp_t RSP,
	// Flash pins
	output fcsu_pkg::fcsu_pins_t PINS,
	input wire logic [15:0] DQ_IN
);
	import fcsu_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Sequencer state

	fcsu_state_t state_q, state_d;
	fcsu_req_t req_q, req_d;
	fcsu_pins_t pins_q, pins_d;
	fcsu_rsp_t rsp_q, rsp_d;
	logic [3:0] cnt_q, cnt_d;
	logic [1:0] step_q, step_d;
	logic [7:0] sticky_q, sticky_d;
	logic rsp_v_q, rsp_v_d;
	logic ready_q;
	logic is_read;
	logic [1:0] last_step;
	logic [15:0] cyc_data;
	logic [19:0] cyc_addr;
	logic polls;
	logic refuse;
	logic [19:0] pr_pair;

	always_comb begin
		pr_pair = req_q.addr ^ 20'h00001;
		// Cycle count, address, data per step of each order
		last_step = 2'd0;
		is_read = 1'b0;
		polls = 1'b0;
		cyc_addr = 20'h00000;
		cyc_data = 16'h0000;
		case (req_q.op)
			OP_WRITE: begin
				cyc_addr = req_q.addr;
				cyc_data = req_q.data;
			end
			OP_READ: begin
				is_read = 1'b1;
				cyc_addr = req_q.addr;
			end
			OP_ERASE: begin
				last_step = 2'd1;
				polls = 1'b1;
				cyc_data = (step_q == 2'd0) ? {8'h00, CMD_ERASE} :
					{8'h00, CMD_CONFIRM};
				cyc_addr = (step_q == 2'd0) ? 20'h00000 : req_q.addr;
			end
			OP_PROGRAM, OP_PROT: begin
				last_step = 2'd1;
				polls = 1'b1;
				cyc_data = (step_q != 2'd0) ? req_q.data :
					{8'h00, (req_q.op == OP_PROT) ? CMD_PROT :
					CMD_PROGRAM};
				cyc_addr = (step_q == 2'd0) ? 20'h00000 : req_q.addr;
			end
			OP_DUAL: begin
				last_step = 2'd2;
				polls = 1'b1;
				cyc_data = (step_q == 2'd0) ? {8'h00, CMD_DUAL} :
					(step_q == 2'd1) ? req_q.data : req_q.data2;
				// Second word differs only in A0
				cyc_addr = (step_q == 2'd0) ? 20'h00000 :
					(step_q == 2'd1) ? req_q.addr : pr_pair;
			end
			OP_PROT_LOCK: begin
				last_step = 2'd1;
				polls = 1'b1;
				cyc_data = (step_q == 2'd0) ? {8'h00, CMD_PROT} :
					PROT_LOCK_DATA;
				cyc_addr = (step_q == 2'd0) ? 20'h00000 : PROT_LOCK_ADDR;
			end
			OP_LOCK: begin
				last_step = 2'd1;
				cyc_data = (step_q == 2'd0) ? {8'h00, CMD_LOCK} :
					{8'h00, req_q.sub};
				cyc_addr = (step_q == 2'd0) ? 20'h00000 : req_q.addr;
			end
			OP_STATUS: begin
				cyc_data = {8'h00, CMD_STATUS};
				last_step = 2'd1;
				is_read = (step_q == 2'd1);
			end
			OP_CLEAR: cyc_data = {8'h00, CMD_CLEAR};
			OP_ARRAY: cyc_data = {8'h00, CMD_READ};
			OP_IDREAD, OP_B_STATE: begin
				last_step = 2'd1;
				cyc_data = {8'h00, CMD_IDENT};
				is_read = (step_q == 2'd1);
				// Upper address bits stay zero for ID space
				cyc_addr = (step_q == 2'd0) ? 20'h00000 :
					(req_q.op == OP_B_STATE) ? PROT_LOCK_ADDR :
					{12'h000, req_q.addr[7:0]};
			end
			default: ;
		endcase
	end

	// Refuse orders the device would reject while errors stand
	always_comb begin
		refuse = 1'b0;
		case (REQ.op)
			OP_PROGRAM, OP_DUAL, OP_PROT, OP_PROT_LOCK:
				refuse = sticky_q[SB_SUPPLY_ERR];
			OP_ERASE:
				refuse = sticky_q[SB_SUPPLY_ERR] ||
					sticky_q[SB_LOCK_ABORT];
			default: refuse = 1'b0;
		endcase
		if (REQ.op == OP_PROT && (REQ.addr < PROT_LO ||
			REQ.addr > PROT_HI))
			refuse = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// Next-state logic

	always_comb begin
		state_d = state_q;
		req_d = req_q;
		pins_d = pins_q;
		rsp_d = rsp_q;
		cnt_d = cnt_q;
		step_d = step_q;
		sticky_d = sticky_q;
		rsp_v_d = 1'b0;
		case (state_q)
			ST_IDLE: begin
				// An order is only taken while ready is shown
				if (REQ_VALID && ready_q) begin
					rsp_d = '0;
					if (refuse) begin
						rsp_d.refused = 1'b1;
						rsp_d.status = sticky_q;
						rsp_v_d = 1'b1;
					end else begin
						req_d = REQ;
						step_d = 2'd0;
						cnt_d = SETUP_CYC;
						state_d = ST_SETUP;
					end
				end
			end
			ST_SETUP: begin
				// Only the low byte carries the command
				pins_d.addr = cyc_addr;
				pins_d.dq_out = cyc_data;
				pins_d.dq_oe = !is_read;
				pins_d.ce_n = 1'b0;
				// Address and data stand a full count before the strobe
				if (cnt_q == 4'd0) begin
					cnt_d = PULSE_CYC;
					pins_d.oe_n = !is_read;
					pins_d.we_n = is_read;
					state_d = ST_PULSE;
				end else begin
					cnt_d = cnt_q - 4'd1;
				end
			end
			ST_PULSE: begin
				if (cnt_q <= 4'd1) begin
					if (is_read)
						rsp_d.data = DQ_IN;
					pins_d = pins_q;
					pins_d.ce_n = 1'b1;
					pins_d.oe_n = 1'b1;
					pins_d.we_n = 1'b1;
					pins_d.dq_oe = 1'b0;
					cnt_d = RECOVER_CYC;
					state_d = ST_RECOVER;
				end else begin
					cnt_d = cnt_q - 4'd1;
				end
			end
			ST_RECOVER: begin
				if (cnt_q <= 4'd1)
					state_d = ST_NEXT;
				else
					cnt_d = cnt_q - 4'd1;
			end
			ST_NEXT: begin
				cnt_d = SETUP_CYC;
				if (step_q != last_step) begin
					step_d = step_q + 2'd1;
					state_d = ST_SETUP;
				end else if (req_q.op == OP_STATUS || polls) begin
					state_d = ST_POLL;
				end else begin
					state_d = ST_DONE;
				end
			end
			ST_POLL: begin
				// Status reads until the machine reports ready
				if (req_q.op != OP_STATUS && !rsp_q.data[SB_READY]) begin
					req_d.op = OP_STATUS;
					step_d = 2'd1;
					state_d = ST_SETUP;
				end else begin
					state_d = ST_DONE;
				end
				if (req_q.op == OP_STATUS && polls == 1'b0 &&
					!rsp_q.data[SB_READY]) begin
					step_d = 2'd1;
					state_d = ST_SETUP;
				end
			end
			ST_DONE: begin
				if (req_q.op == OP_CLEAR)
					sticky_d = 8'h00;
				else if (req_q.op == OP_STATUS)
					sticky_d = rsp_q.data[7:0] & 8'h3A;
				rsp_d.status = (req_q.op == OP_CLEAR) ? 8'h00 :
					sticky_d;
				// Decode error kinds from bits 5,4,3,1
				rsp_d.err = sticky_d[SB_PROG_ERR] ||
					sticky_d[SB_ERASE_ERR] || sticky_d[SB_SUPPLY_ERR] ||
					sticky_d[SB_LOCK_ABORT];
				if (req_q.op == OP_B_STATE)
					rsp_d.data = {15'h0000, rsp_q.data[1]};
				rsp_v_d = 1'b1;
				state_d = ST_IDLE;
			end
			default: state_d = ST_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			state_q <= ST_IDLE;
			req_q <= '0;
			pins_q <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
				addr: 20'h00000, dq_out: 16'h0000, dq_oe: 1'b0};
			rsp_q <= '0;
			cnt_q <= 4'h0;
			step_q <= 2'd0;
			sticky_q <= 8'h00;
			rsp_v_q <= 1'b0;
		end else begin
			state_q <= state_d;
			req_q <= req_d;
			pins_q <= pins_d;
			rsp_q <= rsp_d;
			cnt_q <= cnt_d;
			step_q <= step_d;
			sticky_q <= sticky_d;
			rsp_v_q <= rsp_v_d;
		end
	end

	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N)
			ready_q <= 1'b0;
		else
			ready_q <= (state_d == ST_IDLE) && !rsp_v_d;
	end

	assign REQ_READY = ready_q;
	assign RSP_VALID = rsp_v_q;
	assign RSP = rsp_q;
	assign PINS = pins_q;

endmodule : fcsu_host

`default_nettype wire

// ===== verilog/fcsu_pkg.sv
// Constants, command codes and carrier types of the flash host controller.
// Assumes a 16-bit parallel NOR flash with strobed async pins, run at 40 MHz.
//
// Function
// - Erase: 20 anywhere, D0 in sector.
// - Toggle read strobe between status polls.
// - Error bits sticky; only 50 clears them.
// - FF returns array read; issue it last.
// - Dual program E0, addresses differ in A0.
// - Lock sector B: C0, FFFD at 80.
// - Word program: 40 or 10, then data.
`default_nettype none

package fcsu_pkg;

	localparam logic [7:0] CMD_READ = 8'hFF;
	localparam logic [7:0] CMD_ERASE = 8'h20;
	localparam logic [7:0] CMD_CONFIRM = 8'hD0;
	localparam logic [7:0] CMD_PROGRAM = 8'h40;
	localparam logic [7:0] CMD_DUAL = 8'hE0;
	localparam logic [7:0] CMD_SUSPEND = 8'hB0;
	localparam logic [7:0] CMD_IDENT = 8'h90;
	localparam logic [7:0] CMD_LOCK = 8'h60;
	localparam logic [7:0] CMD_SOFTLOCK = 8'h01;
	localparam logic [7:0] CMD_HARDLOCK = 8'h2F;
	localparam logic [7:0] CMD_STATUS = 8'h70;
	localparam logic [7:0] CMD_CLEAR = 8'h50;
	localparam logic [7:0] CMD_PROT = 8'hC0;
	localparam logic [7:0] CMD_QUERY = 8'h98;
	localparam logic [15:0] PROT_LOCK_DATA = 16'hFFFD;
	localparam logic [19:0] PROT_LOCK_ADDR = 20'h00080;
	localparam logic [19:0] PROT_LO = 20'h00081;
	localparam logic [19:0] PROT_HI = 20'h00088;

	// Status bit positions
	localparam int SB_READY = 7;
	localparam int SB_ERASE_ERR = 5;
	localparam int SB_PROG_ERR = 4;
	localparam int SB_SUPPLY_ERR = 3;
	localparam int SB_LOCK_ABORT = 1;

	// Bus timing: setup/pulse/recovery
	localparam int CLK_PERIOD_NS = 25;
	localparam int T_SETUP_NS = 20;
	localparam int T_PULSE_NS = 70;
	localparam int T_RECOVER_NS = 25;
	localparam logic [3:0] SETUP_CYC =
		4'((T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] PULSE_CYC =
		4'((T_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] RECOVER_CYC =
		4'((T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	typedef enum logic [4:0] {
		OP_WRITE = 5'h00,
		OP_READ = 5'h01,
		OP_ERASE = 5'h02,
		OP_PROGRAM = 5'h03,
		OP_DUAL = 5'h04,
		OP_PROT = 5'h05,
		OP_PROT_LOCK = 5'h06,
		OP_LOCK = 5'h07,
		OP_STATUS = 5'h08,
		OP_CLEAR = 5'h09,
		OP_ARRAY = 5'h0A,
		OP_IDREAD = 5'h0B,
		OP_B_STATE = 5'h0C
	} fcsu_op_t;

	typedef struct packed {
		fcsu_op_t op;
		logic [19:0] addr;
		logic [15:0] data;
		logic [15:0] data2;
		logic [7:0] sub;
	} fcsu_req_t;

	typedef struct packed {
		logic [15:0] data;
		logic [7:0] status;
		logic refused;
		logic err;
	} fcsu_rsp_t;

	typedef struct packed {
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic [19:0] addr;
		logic [15:0] dq_out;
		logic dq_oe;
	} fcsu_pins_t;

	typedef enum logic [6:0] {
		ST_IDLE = 7'b0000001,
		ST_SETUP = 7'b0000010,
		ST_PULSE = 7'b0000100,
		ST_RECOVER = 7'b0001000,
		ST_NEXT = 7'b0010000,
		ST_POLL = 7'b0100000,
		ST_DONE = 7'b1000000
	} fcsu_state_t;

endpackage : fcsu_pkg

`default_nettype wire

// ===== test/fcsu_host_asserts.sv
// Checker for the flash host controller, bound to its top ports.
// Assumes pins registered on CORE_CLK.
`default_nettype none
module fcsu_host_asserts (
	// Clock and reset
	input wire logic CORE_CLK,
	input wire logic RESET_N,
	// Orders
	input wire logic REQ_VALID,
	input wire fcsu_pkg::fcsu_req_t REQ,
	input wire logic REQ_READY,
	input wire logic RSP_VALID,
	input wire fcsu_pkg::fcsu_rsp_t RSP,
	// Flash pins
	input wire fcsu_pkg::fcsu_pins_t PINS,
	input wire logic [15:0] DQ_IN
);
	import fcsu_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RESET_N);
	sequence wr(logic [15:0] c);
		$fell(PINS.we_n) && PINS.dq_out == c;
	endsequence
	sequence take(fcsu_op_t o);
		REQ_VALID && REQ_READY && REQ.op == o;
	endsequence
	chk_write_pulse: assert property ($fell(PINS.we_n) |->
		!PINS.we_n [*3] ##1 PINS.we_n) else $error("bad write pulse");
	chk_read_pulse: assert property ($fell(PINS.oe_n) |->
		!PINS.oe_n [*3] ##1 PINS.oe_n) else $error("bad read pulse");
	chk_erase_confirm: assert property (wr(16'h0020) |->
		##[4:10] wr(16'h00D0)) else $error("no confirm");
	chk_status_read: assert property (wr(16'h0070) |->
		##[4:10] $fell(PINS.oe_n)) else $error("no status read");
	chk_clear_code: assert property (take(OP_CLEAR) |->
		##[1:8] wr(16'h0050)) else $error("no clear code");
	chk_array_code: assert property (take(OP_ARRAY) |->
		##[1:8] wr(16'h00FF)) else $error("no read code");
	chk_prot_range: assert property (REQ_VALID && REQ_READY &&
		REQ.op == OP_PROT && !(REQ.addr inside {[PROT_LO:PROT_HI]})
		|-> ##1 RSP_VALID && RSP.refused) else $error("range");
	chk_refuse_quiet: assert property (RSP_VALID && RSP.refused |->
		PINS.ce_n && $past(PINS.ce_n) && $past(PINS.ce_n, 2))
		else $error("refused but pins active");
endmodule // fcsu_host_asserts
bind fcsu_host fcsu_host_asserts chk (.CORE_CLK, .RESET_N, .REQ_VALID,
	.REQ, .REQ_READY, .RSP_VALID, .RSP, .PINS, .DQ_IN);
`default_nettype wire

// ===== test/fcsu_flash.sv
// Behavioural flash device answering the host's strobed pins.
// Assumes the bench sets the fail, lock and low-supply knobs.
`default_nettype none
module fcsu_flash (
	// Pins
	input wire fcsu_pkg::fcsu_pins_t pins,
	output logic [15:0] dq,
	// Knobs
	input wire logic fail,
	input wire logic lock,
	input wire logic vlow
);
	import fcsu_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	// Arbitrary maker code
	parameter logic [15:0] MAKER = 16'h5A3C;
	logic [7:0] cmd = 8'hFF, sr = 8'h80, last = 8'h00, d, pe;
	logic [1:0] mode = 2'h0;
	logic bfree = 1'b1;
	logic [19:0] a0 = '0, a1 = '0;
	logic [15:0] rd;
	time t_rdy = 0;
	logic wr_on = 1'b0;
	////////////////////////////////
	// Released bus shows the inverse, never a stale value
	assign dq = (!pins.ce_n && !pins.oe_n) ? rd : ~rd;
	always_comb
		if (mode == 2'h1) rd = {8'h00, sr};
		else if (mode == 2'h0 || pins.addr > PROT_LOCK_ADDR) rd = 16'h0000;
		else if (pins.addr == 20'h0) rd = MAKER;
		else rd = {14'h0, bfree, 1'b0};
	always @(negedge pins.oe_n) sr[7] = $time >= t_rdy;
	always @(pins) wr_on = !pins.ce_n && !pins.we_n;
	// A write ends when the first of chip or write enable rises
	always @(negedge wr_on) begin
		d = pins.dq_out[7:0];
		pe = cmd == CMD_ERASE ? 8'h20 : 8'h10;
		case (cmd)
			CMD_ERASE, CMD_PROGRAM, CMD_PROT, 8'hE1: begin
				a1 = pins.addr;
				mode = 2'h1;
				t_rdy = $time + (cmd == CMD_ERASE ? 2000 : 100);
				if (cmd == CMD_PROT && pins.addr == PROT_LOCK_ADDR)
					bfree = pins.dq_out[1];
				else if (cmd == CMD_ERASE && d != CMD_CONFIRM)
					sr |= 8'h30;
				else if (cmd == CMD_PROT && !(pins.addr inside {[PROT_LO:PROT_HI]}))
					sr |= 8'h10;
				else if (vlow)
					sr |= 8'h08 | (pe & 8'h10);
				else if (lock)
					sr |= cmd == CMD_PROT ? 8'h12 : 8'h02;
				else if (fail)
					sr |= pe;
				cmd = CMD_READ;
			end
			CMD_DUAL: begin
				a0 = pins.addr;
				cmd = 8'hE1;
			end
			CMD_LOCK: begin
				last = d;
				cmd = CMD_READ;
			end
			default: begin
				cmd = d;
				if (d == CMD_READ) mode = 2'h0;
				if (d == CMD_STATUS) mode = 2'h1;
				if (d == CMD_IDENT) mode = 2'h2;
				if (d == CMD_CLEAR) sr &= 8'h80;
			end
		endcase
	end
endmodule // fcsu_flash
`default_nettype wire

// ===== test/fcsu_host_bench.sv
// Self-checking bench: orders through the user port, device model behind.
// Assumes the checker is bound by its own file.
`default_nettype none
module fcsu_host_bench;
	import fcsu_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst_n = 0, req_valid = 0, fail = 0, lock = 0, vlow = 0;
	logic req_ready, rsp_valid;
	fcsu_req_t req = '0;
	fcsu_rsp_t rsp, got;
	fcsu_pins_t pins;
	logic [15:0] dq;
	logic [7:0] subs [3] = '{8'h01, 8'h2F, 8'hD0};
	int error_cnt = 0, check_count = 0, cycles = 0;
	always #12.5 clk = ~clk;
	fcsu_host uut (.CORE_CLK(clk), .RESET_N(rst_n), .REQ_VALID(req_valid),
		.REQ(req), .REQ_READY(req_ready), .RSP_VALID(rsp_valid), .RSP(rsp),
		.PINS(pins), .DQ_IN(dq));
	fcsu_flash fl (.pins(pins), .dq(dq), .fail(fail), .lock(lock),
		.vlow(vlow));
	////////////////////////////////
	task automatic conclude;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	// Holds the order until the edge that takes it
	task automatic op(input fcsu_op_t o, input logic [19:0] a,
		input logic [15:0] d = 16'h1234, input logic [7:0] s = 8'h00);
		do @(posedge clk); while (req_ready !== 1'b1);
		req_valid <= 1'b1;
		req <= '{o, a, d, ~d, s};
		do @(posedge clk); while (req_ready !== 1'b1);
		req_valid <= 1'b0;
		do @(posedge clk); while (rsp_valid !== 1'b1);
		got = rsp;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			conclude;
		end
	end
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		op(OP_ERASE, 20'h08123);
		chk({got.refused, got.status, fl.a1}, {9'h000, 20'h08123});
		chk($time >= fl.t_rdy, 1'b1);
		fail <= 1'b1;
		op(OP_PROGRAM, 20'h00400);
		chk({got.err, got.status}, 9'h110);
		op(OP_STATUS, 0);
		chk(got.status, 8'h10);
		op(OP_CLEAR, 0);
		op(OP_ERASE, 20'h10000);
		chk(got.status, 8'h20);
		op(OP_CLEAR, 0);
		chk({got.err, got.status}, 9'h000);
		fail <= 1'b0;
		lock <= 1'b1;
		op(OP_PROGRAM, 20'h00400);
		chk(got.status, 8'h02);
		op(OP_ERASE, 20'h10000);
		chk({got.refused, got.status}, 9'h102);
		op(OP_CLEAR, 0);
		op(OP_ERASE, 20'h10000);
		chk(got.status, 8'h02);
		op(OP_CLEAR, 0);
		op(OP_PROT, 20'h00085);
		chk(got.status, 8'h12);
		op(OP_CLEAR, 0);
		lock <= 1'b0;
		op(OP_PROT, 20'h00185);
		chk(got.refused, 1'b1);
		vlow <= 1'b1;
		op(OP_PROT, 20'h00086);
		chk(got.status, 8'h18);
		vlow <= 1'b0;
		op(OP_PROGRAM, 20'h00400);
		chk(got.refused, 1'b1);
		op(OP_ERASE, 20'h10000);
		chk(got.refused, 1'b1);
		op(OP_CLEAR, 0);
		op(OP_IDREAD, 0);
		chk(got.data, fl.MAKER);
		op(OP_B_STATE, PROT_LOCK_ADDR);
		chk(got.data[0], 1'b1);
		op(OP_PROT_LOCK, PROT_LOCK_ADDR, PROT_LOCK_DATA);
		op(OP_B_STATE, PROT_LOCK_ADDR);
		chk(got.data[0], 1'b0);
		for (int i = 0; i < 3; i++) begin
			op(OP_LOCK, 20'h18000, 0, subs[i]);
			chk(fl.last, subs[i]);
		end
		op(OP_DUAL, 20'h00600);
		chk(fl.a0 ^ fl.a1, 20'h00001);
		op(OP_ARRAY, 0);
		chk(fl.mode, 2'h0);
		conclude;
	end
endmodule // fcsu_host_bench
`default_nettype wire
